/* lim_pkg.sv */
// shared types and constants for the literal and indirect move executor
package lim_pkg;

  typedef enum logic [2:0] {
    LIM_OP_NOP,
    LIM_OP_LOAD_BANK_LITERAL,
    LIM_OP_LOAD_PAGE_LATCH_LITERAL,
    LIM_OP_LOAD_WORK_LITERAL,
    LIM_OP_STORE_WORK_TO_FILE,
    LIM_OP_STORE_WORK_INDIRECT
  } lim_op_e;

  typedef struct packed {
    lim_op_e     op;
    logic [7:0]  literal;
    logic [6:0]  file_addr;
    logic        ptr_sel;
    logic [1:0]  pointer_mode_field;
    logic        relative;
    logic [5:0]  offset;
  } lim_instr_s;

  typedef struct packed {
    logic        we;
    logic [15:0] addr;
    logic [7:0]  data;
  } lim_wr_s;

  // pointer mode field bit meaning
  localparam int LIM_MODE_DEC_BIT  = 0;
  localparam int LIM_MODE_POST_BIT = 1;

  // file addresses decoded in the core; the two aliases and LIM_FILE_CORE_TOP and up write to data space
  localparam logic [6:0] LIM_FILE_ALIAS0    = 7'h00;
  localparam logic [6:0] LIM_FILE_ALIAS1    = 7'h01;
  localparam logic [6:0] LIM_FILE_PTR0_LO   = 7'h04;
  localparam logic [6:0] LIM_FILE_PTR0_HI   = 7'h05;
  localparam logic [6:0] LIM_FILE_PTR1_LO   = 7'h06;
  localparam logic [6:0] LIM_FILE_PTR1_HI   = 7'h07;
  localparam logic [6:0] LIM_FILE_BANK      = 7'h08;
  localparam logic [6:0] LIM_FILE_WORK      = 7'h09;
  localparam logic [6:0] LIM_FILE_PAGE      = 7'h0A;
  localparam logic [6:0] LIM_FILE_CORE_TOP  = 7'h0C;

  // wishbone register byte offsets
  localparam logic [7:0] LIM_OFF_CTRL   = 8'h00;
  localparam logic [7:0] LIM_OFF_WORK   = 8'h04;
  localparam logic [7:0] LIM_OFF_BANK   = 8'h08;
  localparam logic [7:0] LIM_OFF_PAGE   = 8'h0C;
  localparam logic [7:0] LIM_OFF_PTR0   = 8'h10;
  localparam logic [7:0] LIM_OFF_PTR1   = 8'h14;
  localparam logic [7:0] LIM_OFF_STATUS = 8'h18;
  localparam logic [7:0] LIM_OFF_COUNT  = 8'h1C;

  // values after reset
  localparam logic        LIM_RST_ENABLE = 1'b1;
  localparam logic [7:0]  LIM_RST_WORK   = 8'h00;
  localparam logic [4:0]  LIM_RST_BANK   = 5'h00;
  localparam logic [6:0]  LIM_RST_PAGE   = 7'h00;
  localparam logic [15:0] LIM_RST_PTR    = 16'h0000;
  localparam logic [7:0]  LIM_RST_STATUS = 8'h00;

endpackage

/* lim_ptr_calc.sv */
// effective address and next pointer value for an indirect store
`timescale 1ns/100ps
module lim_ptr_calc
  import lim_pkg::*;
(
  input  wire logic [15:0] ptr_i,
  input  wire logic [1:0]  mode_i,
  input  wire logic        relative_i,
  input  wire logic [5:0]  offset_i,
  output logic      [15:0] eff_addr_o,
  output logic      [15:0] ptr_nxt_o
);

  logic [15:0] stepped;
  logic [15:0] rel_addr;

  // 16-bit arithmetic wraps on its own at both ends
  assign stepped  = mode_i[LIM_MODE_DEC_BIT] ? ptr_i - 16'h0001 : ptr_i + 16'h0001;
  assign rel_addr = ptr_i + {{10{offset_i[5]}}, offset_i};

  always_comb
  begin
    if (relative_i)
    begin
      eff_addr_o = rel_addr;
      ptr_nxt_o  = ptr_i;
    end
    else
    begin
      eff_addr_o = mode_i[LIM_MODE_POST_BIT] ? ptr_i : stepped;
      ptr_nxt_o  = stepped;
    end
  end

endmodule

/* lim_exec.sv */
// executor for literal loads, direct stores and indirect stores
`timescale 1ns/100ps
module lim_exec
  import lim_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ins_valid_i,
  input  wire lim_instr_s  ins_i,
  output lim_wr_s          mem_wr_o,
  output logic             done_o,
  output logic      [7:0]  work_o,
  output logic      [4:0]  bank_o,
  output logic      [6:0]  page_o,
  output logic      [15:0] ptr0_o,
  output logic      [15:0] ptr1_o,
  output logic      [7:0]  status_o,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o
);

  logic        enable_ff;
  logic [7:0]  work_ff;
  logic [4:0]  bank_ff;
  logic [6:0]  page_ff;
  logic [15:0] ptr_ff [0:1];
  logic [7:0]  status_ff;
  logic [15:0] count_ff;
  lim_wr_s     wr_ff;
  logic        done_ff;
  logic        wb_ack_ff;
  logic [31:0] wb_dat_ff;

  logic        exec;
  logic        is_bank;
  logic        is_page;
  logic        is_work;
  logic        is_file;
  logic        is_ind;
  logic [15:0] sel_ptr;
  logic [15:0] eff_addr;
  logic [15:0] ptr_nxt;
  logic        wb_take;
  logic        wb_wr;
  logic [7:0]  wb_off;
  logic [31:0] nxt_wb_dat;

  // disabled core ignores issued instructions entirely
  assign exec    = ins_valid_i && enable_ff;
  assign is_bank = exec && (ins_i.op == LIM_OP_LOAD_BANK_LITERAL);
  assign is_page = exec && (ins_i.op == LIM_OP_LOAD_PAGE_LATCH_LITERAL);
  assign is_work = exec && (ins_i.op == LIM_OP_LOAD_WORK_LITERAL);
  assign is_file = exec && (ins_i.op == LIM_OP_STORE_WORK_TO_FILE);
  assign is_ind  = exec && (ins_i.op == LIM_OP_STORE_WORK_INDIRECT);
  assign sel_ptr = ptr_ff[ins_i.ptr_sel];

  lim_ptr_calc u_ptr_calc (
    .ptr_i      (sel_ptr),
    .mode_i     (ins_i.pointer_mode_field),
    .relative_i (ins_i.relative),
    .offset_i   (ins_i.offset),
    .eff_addr_o (eff_addr),
    .ptr_nxt_o  (ptr_nxt)
  );

  // one request per ack; the gap cycle keeps a held stb from firing twice
  assign wb_take = wb_cyc_i && wb_stb_i && !wb_ack_ff;
  // writes land on the edge that sees ack, while the master still holds
  assign wb_wr   = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_ff;
  assign wb_off  = {wb_adr_i[7:2], 2'b00};

  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  sel);
    merge16 = old_v;
    if (sel[0])
      merge16[7:0] = new_v[7:0];
    if (sel[1])
      merge16[15:8] = new_v[15:8];
  endfunction

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      enable_ff <= LIM_RST_ENABLE;
    else if (wb_wr && wb_off == LIM_OFF_CTRL && wb_sel_i[0])
      enable_ff <= wb_dat_i[0];
  end

  // instructions win over a software write in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      work_ff <= LIM_RST_WORK;
    else if (is_work)
      work_ff <= ins_i.literal;
    else if (is_file && ins_i.file_addr == LIM_FILE_WORK)
      work_ff <= work_ff;
    else if (wb_wr && wb_off == LIM_OFF_WORK && wb_sel_i[0])
      work_ff <= wb_dat_i[7:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      bank_ff <= LIM_RST_BANK;
    else if (is_bank)
      bank_ff <= ins_i.literal[4:0];
    else if (is_file && ins_i.file_addr == LIM_FILE_BANK)
      bank_ff <= work_ff[4:0];
    else if (wb_wr && wb_off == LIM_OFF_BANK && wb_sel_i[0])
      bank_ff <= wb_dat_i[4:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      page_ff <= LIM_RST_PAGE;
    else if (is_page)
      page_ff <= ins_i.literal[6:0];
    else if (is_file && ins_i.file_addr == LIM_FILE_PAGE)
      page_ff <= work_ff[6:0];
    else if (wb_wr && wb_off == LIM_OFF_PAGE && wb_sel_i[0])
      page_ff <= wb_dat_i[6:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ptr_ff[0] <= LIM_RST_PTR;
      ptr_ff[1] <= LIM_RST_PTR;
    end
    else if (is_ind)
      ptr_ff[ins_i.ptr_sel] <= ptr_nxt;
    else if (is_file)
    begin
      unique case (ins_i.file_addr)
        LIM_FILE_PTR0_LO: ptr_ff[0][7:0]  <= work_ff;
        LIM_FILE_PTR0_HI: ptr_ff[0][15:8] <= work_ff;
        LIM_FILE_PTR1_LO: ptr_ff[1][7:0]  <= work_ff;
        LIM_FILE_PTR1_HI: ptr_ff[1][15:8] <= work_ff;
        default: ;
      endcase
    end
    else if (wb_wr && wb_off == LIM_OFF_PTR0)
      ptr_ff[0] <= merge16(ptr_ff[0], wb_dat_i, wb_sel_i);
    else if (wb_wr && wb_off == LIM_OFF_PTR1)
      ptr_ff[1] <= merge16(ptr_ff[1], wb_dat_i, wb_sel_i);
  end

  // no instruction of this group has a path into the flags
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      status_ff <= LIM_RST_STATUS;
    else if (wb_wr && wb_off == LIM_OFF_STATUS && wb_sel_i[0])
      status_ff <= wb_dat_i[7:0];
  end

  // count wraps; software only ever looks at differences
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      count_ff <= 16'h0000;
    else if (exec && ins_i.op != LIM_OP_NOP)
      count_ff <= count_ff + 16'h0001;
  end

  // data space write port, one cycle after issue
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wr_ff <= '0;
    else
    begin
      wr_ff.we   <= 1'b0;
      wr_ff.data <= work_ff;
      wr_ff.addr <= wr_ff.addr;
      if (is_ind)
      begin
        wr_ff.we   <= 1'b1;
        wr_ff.addr <= eff_addr;
      end
      else if (is_file && ins_i.file_addr == LIM_FILE_ALIAS0)
      begin
        wr_ff.we   <= 1'b1;
        wr_ff.addr <= ptr_ff[0];
      end
      else if (is_file && ins_i.file_addr == LIM_FILE_ALIAS1)
      begin
        wr_ff.we   <= 1'b1;
        wr_ff.addr <= ptr_ff[1];
      end
      else if (is_file && ins_i.file_addr >= LIM_FILE_CORE_TOP)
      begin
        wr_ff.we   <= 1'b1;
        wr_ff.addr <= {4'h0, bank_ff, ins_i.file_addr};
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      done_ff <= 1'b0;
    else
      done_ff <= exec && ins_i.op != LIM_OP_NOP;
  end

  always_comb
  begin
    nxt_wb_dat = 32'h0000_0000;
    unique case (wb_off)
      LIM_OFF_CTRL:   nxt_wb_dat[0]    = enable_ff;
      LIM_OFF_WORK:   nxt_wb_dat[7:0]  = work_ff;
      LIM_OFF_BANK:   nxt_wb_dat[4:0]  = bank_ff;
      LIM_OFF_PAGE:   nxt_wb_dat[6:0]  = page_ff;
      LIM_OFF_PTR0:   nxt_wb_dat[15:0] = ptr_ff[0];
      LIM_OFF_PTR1:   nxt_wb_dat[15:0] = ptr_ff[1];
      LIM_OFF_STATUS: nxt_wb_dat[7:0]  = status_ff;
      LIM_OFF_COUNT:  nxt_wb_dat[15:0] = count_ff;
      default:        nxt_wb_dat       = 32'h0000_0000;
    endcase
  end

  // unmapped offsets still ack, reading zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_ff <= 1'b0;
      wb_dat_ff <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_ff <= wb_take;
      if (wb_take && !wb_we_i)
        wb_dat_ff <= nxt_wb_dat;
    end
  end

  assign mem_wr_o = wr_ff;
  assign done_o   = done_ff;
  assign work_o   = work_ff;
  assign bank_o   = bank_ff;
  assign page_o   = page_ff;
  assign ptr0_o   = ptr_ff[0];
  assign ptr1_o   = ptr_ff[1];
  assign status_o = status_ff;
  assign wb_dat_o = wb_dat_ff;
  assign wb_ack_o = wb_ack_ff;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_ind_issue(logic [1:0] m);
    is_ind && !ins_i.relative && ins_i.pointer_mode_field == m;
  endsequence

  sequence s_wr_at(logic [15:0] a);
    wr_ff.we && wr_ff.addr == a;
  endsequence

  property p_bank_load;
    is_bank |=> bank_ff == $past(ins_i.literal[4:0]);
  endproperty
  a_bank_load: assert property (p_bank_load) else $error("bank not loaded");

  property p_page_load;
    is_page |=> page_ff == $past(ins_i.literal[6:0]) && !wr_ff.we;
  endproperty
  a_page_load: assert property (p_page_load) else $error("page latch not loaded");

  property p_work_load;
    is_work |=> work_ff == $past(ins_i.literal);
  endproperty
  a_work_load: assert property (p_work_load) else $error("work not loaded");

  property p_direct_store;
    is_file && ins_i.file_addr >= LIM_FILE_CORE_TOP |=>
      wr_ff.we && wr_ff.data == $past(work_ff)
      && wr_ff.addr == {4'h0, $past(bank_ff), $past(ins_i.file_addr)};
  endproperty
  a_direct_store: assert property (p_direct_store) else $error("direct store wrong");

  property p_alias_store;
    is_file && ins_i.file_addr == LIM_FILE_ALIAS1 |=> s_wr_at($past(ptr_ff[1]));
  endproperty
  a_alias_store: assert property (p_alias_store) else $error("alias not redirected");

  property p_pre_inc;
    s_ind_issue(2'b00) |=> s_wr_at($past(sel_ptr) + 16'h0001)
      ##0 wr_ff.data == $past(work_ff);
  endproperty
  a_pre_inc: assert property (p_pre_inc) else $error("pre-increment wrong");

  property p_post_dec;
    s_ind_issue(2'b11) |=> s_wr_at($past(sel_ptr))
      ##0 ptr_ff[$past(ins_i.ptr_sel)] == $past(sel_ptr) - 16'h0001;
  endproperty
  a_post_dec: assert property (p_post_dec) else $error("post-decrement wrong");

  property p_relative;
    is_ind && ins_i.relative |=>
      s_wr_at($past(sel_ptr) + {{10{$past(ins_i.offset[5])}}, $past(ins_i.offset)})
      ##0 ptr_ff[$past(ins_i.ptr_sel)] == $past(sel_ptr);
  endproperty
  a_relative: assert property (p_relative) else $error("relative store wrong");

  property p_wrap;
    s_ind_issue(2'b00) ##0 sel_ptr == 16'hFFFF |=> s_wr_at(16'h0000);
  endproperty
  a_wrap: assert property (p_wrap) else $error("pointer did not wrap");

  property p_flags_kept;
    exec && !wb_wr |=> $stable(status_ff);
  endproperty
  a_flags_kept: assert property (p_flags_kept) else $error("flags changed");

  property p_one_cycle;
    exec && ins_i.op != LIM_OP_NOP |=> done_ff ##1 (!done_ff || $past(exec));
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("done not a single cycle");

endmodule

/* lim_exec_bench.sv */
// self-checking bench for the literal and indirect move executor
`timescale 1ns/100ps
module lim_exec_bench;
  import lim_pkg::*;

  logic        clk_i       = 1'b0;
  logic        rst_i       = 1'b1;
  logic        ins_valid_i = 1'b0;
  lim_instr_s  ins_i       = '0;
  lim_wr_s     mem_wr_o;
  logic        done_o;
  logic [7:0]  work_o;
  logic [4:0]  bank_o;
  logic [6:0]  page_o;
  logic [15:0] ptr0_o;
  logic [15:0] ptr1_o;
  logic [7:0]  status_o;
  logic        wb_cyc_i    = 1'b0;
  logic        wb_stb_i    = 1'b0;
  logic        wb_we_i     = 1'b0;
  logic [7:0]  wb_adr_i    = 8'h00;
  logic [3:0]  wb_sel_i    = 4'h0;
  logic [31:0] wb_dat_i    = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  int          errors      = 0;
  int          check_count = 0;
  int          cycles      = 0;
  logic [7:0]  e_work, e_st, lit;
  logic [4:0]  e_bank;
  logic [6:0]  e_page, f;
  logic [15:0] e_p0, e_p1, p, np, ea;
  logic [31:0] rd;
  int          n_exec;

  lim_exec lim_exec_i (.clk_i(clk_i), .rst_i(rst_i), .ins_valid_i(ins_valid_i), .ins_i(ins_i),
    .mem_wr_o(mem_wr_o), .done_o(done_o), .work_o(work_o), .bank_o(bank_o), .page_o(page_o),
    .ptr0_o(ptr0_o), .ptr1_o(ptr1_o), .status_o(status_o), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

  always #2 clk_i = ~clk_i;

  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // whole run needs a few hundred cycles
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      errors++;
      finish_test();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // classic single cycle; the bench timeout bounds the wait for ack
  task automatic wb(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                    input logic [31:0] wd, output logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= wd;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1)
      @(posedge clk_i);
    d = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  // results land on the taking edge itself; sampled once settled
  task automatic issue(input lim_op_e op, input logic [7:0] l, input logic [6:0] fa,
                       input logic ps, input logic [1:0] md, input logic rel,
                       input logic [5:0] off, input logic exp_done);
    @(posedge clk_i);
    ins_valid_i <= 1'b1;
    ins_i       <= '{op, l, fa, ps, md, rel, off};
    @(posedge clk_i);
    ins_valid_i <= 1'b0;
    #1;
    if (exp_done)
      n_exec++;
    check("done", 32'(done_o), 32'(exp_done));
    check("status", 32'(status_o), 32'(e_st));
  endtask

  task automatic load_work(input logic [7:0] v);
    issue(LIM_OP_LOAD_WORK_LITERAL, v, 7'h00, 1'b0, 2'b00, 1'b0, 6'h00, 1'b1);
    e_work = v;
  endtask

  initial
  begin
    static logic [7:0] offs [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C,
                                    8'h20};
    static lim_op_e    ops  [3] = '{LIM_OP_LOAD_BANK_LITERAL, LIM_OP_LOAD_PAGE_LATCH_LITERAL,
                              LIM_OP_LOAD_WORK_LITERAL};
    n_exec = 0;
    void'($urandom(32'hB9CC));
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values, unmapped offset reads zero
    foreach (offs[i])
    begin
      wb(1'b0, offs[i], 4'hF, 32'h0, rd);
      check("reset read", rd, (i == 0) ? 32'h1 : 32'h0);
    end
    wb(1'b1, LIM_OFF_STATUS, 4'h1, {24'h0, 8'(($urandom % 255) + 1)}, rd);
    wb(1'b0, LIM_OFF_STATUS, 4'hF, 32'h0, rd);
    e_st = rd[7:0];
    {e_work, e_bank, e_page, e_p0, e_p1} = '0;
    // literal loads, first three at the top of their range
    for (int i = 0; i < 24; i++)
    begin
      lit = (i < 3) ? 8'hFF : 8'($urandom);
      if (i % 3 == 0) lit = lit & 8'h1F;
      if (i % 3 == 1) lit = lit & 8'h7F;
      issue(ops[i % 3], lit, 7'h00, 1'b0, 2'b00, 1'b0, 6'h00, 1'b1);
      if (i % 3 == 0) e_bank = lit[4:0];
      if (i % 3 == 1) e_page = lit[6:0];
      if (i % 3 == 2) e_work = lit;
      check("bank", 32'(bank_o), 32'(e_bank));
      check("page", 32'(page_o), 32'(e_page));
      check("work", 32'(work_o), 32'(e_work));
      check("no write", 32'(mem_wr_o.we), 32'h0);
    end
    // direct stores into data space, both ends of the range
    for (int i = 0; i < 8; i++)
    begin
      f = (i == 0) ? 7'h0C : (i == 1) ? 7'h7F : 7'($urandom_range(12, 127));
      load_work(8'($urandom));
      issue(LIM_OP_STORE_WORK_TO_FILE, 8'h00, f, 1'b0, 2'b00, 1'b0, 6'h00, 1'b1);
      check("dir we", 32'(mem_wr_o.we), 32'h1);
      check("dir addr", 32'(mem_wr_o.addr), 32'({4'h0, e_bank, f}));
      check("dir data", 32'(mem_wr_o.data), 32'(e_work));
    end
    // every mode on both pointers, the stepping modes starting where the step wraps
    for (int i = 0; i < 12; i++)
    begin
      logic       ps;
      logic [1:0] md;
      logic       rel;
      logic [5:0] off;
      ps  = i[0];
      md  = 2'(i >> 1);
      rel = (i >= 8);
      off = (i < 10) ? 6'h20 : 6'h1F;
      p   = (i >= 8) ? 16'($urandom) : md[0] ? 16'h0000 : 16'hFFFF;
      wb(1'b1, ps ? LIM_OFF_PTR1 : LIM_OFF_PTR0, 4'h3, {16'h0, p}, rd);
      load_work(8'($urandom));
      if (ps) e_p1 = p;
      else e_p0 = p;
      np = md[0] ? p - 16'h0001 : p + 16'h0001;
      ea = rel ? p + {{10{off[5]}}, off} : md[1] ? p : np;
      if (rel) np = p;
      issue(LIM_OP_STORE_WORK_INDIRECT, 8'h00, 7'h00, ps, md, rel, off, 1'b1);
      check("ind we", 32'(mem_wr_o.we), 32'h1);
      check("ind data", 32'(mem_wr_o.data), 32'(e_work));
      check("ind addr", 32'(mem_wr_o.addr), 32'(ea));
      check("ptr", 32'(ps ? ptr1_o : ptr0_o), 32'(np));
      check("ind status", 32'(status_o), 32'(e_st));
      if (ps) e_p1 = np;
      else e_p0 = np;
    end
    // alias address redirects through pointer 0, pointer untouched
    load_work(8'h3C);
    issue(LIM_OP_STORE_WORK_TO_FILE, 8'h00, LIM_FILE_ALIAS0, 1'b0, 2'b00, 1'b0, 6'h00, 1'b1);
    check("alias addr", 32'(mem_wr_o.addr), 32'(e_p0));
    check("alias we", 32'(mem_wr_o.we), 32'h1);
    check("alias ptr", 32'(ptr0_o), 32'(e_p0));
    // alias 1 redirects through pointer 1
    issue(LIM_OP_STORE_WORK_TO_FILE, 8'h00, LIM_FILE_ALIAS1, 1'b0, 2'b00, 1'b0, 6'h00, 1'b1);
    check("alias1 addr", 32'(mem_wr_o.addr), 32'(e_p1));
    check("alias1 data", 32'(mem_wr_o.data), 32'(e_work));
    check("alias1 we", 32'(mem_wr_o.we), 32'h1);
    check("alias1 ptr", 32'(ptr1_o), 32'(e_p1));
    // core registers reached by direct store, no data space write
    issue(LIM_OP_STORE_WORK_TO_FILE, 8'h00, LIM_FILE_PTR1_HI, 1'b0, 2'b00, 1'b0, 6'h00, 1'b1);
    e_p1[15:8] = e_work;
    check("file ptr", 32'(ptr1_o), 32'(e_p1));
    check("file ptr we", 32'(mem_wr_o.we), 32'h0);
    issue(LIM_OP_STORE_WORK_TO_FILE, 8'h00, LIM_FILE_PAGE, 1'b0, 2'b00, 1'b0, 6'h00, 1'b1);
    check("file page", 32'(page_o), 32'(e_work[6:0]));
    issue(LIM_OP_STORE_WORK_TO_FILE, 8'h00, LIM_FILE_BANK, 1'b0, 2'b00, 1'b0, 6'h00, 1'b1);
    check("file bank", 32'(bank_o), 32'(e_work[4:0]));
    check("file bank we", 32'(mem_wr_o.we), 32'h0);
    // disabled executor ignores instructions
    wb(1'b1, LIM_OFF_CTRL, 4'h1, 32'h0, rd);
    issue(LIM_OP_LOAD_WORK_LITERAL, 8'hA5, 7'h00, 1'b0, 2'b00, 1'b0, 6'h00, 1'b0);
    check("off work", 32'(work_o), 32'(e_work));
    wb(1'b1, LIM_OFF_CTRL, 4'h1, 32'h1, rd);
    wb(1'b0, LIM_OFF_COUNT, 4'hF, 32'h0, rd);
    check("count", rd, 32'(n_exec));
    finish_test();
  end
endmodule
